// [src/asr_pkg.sv]
package asr_pkg;
  // register offsets on the serial register port
  localparam logic [7:0] OFF_MAKER_CODE = 8'h01;
  localparam logic [7:0] OFF_DEVICE_CODE = 8'h02;
  localparam logic [7:0] OFF_MASK_REVISION = 8'h03;
  localparam logic [7:0] OFF_CONDITION_FLAGS = 8'h04;
  localparam logic [7:0] OFF_QUEUE_FILL = 8'h05;
  localparam logic [7:0] OFF_TEMP_HIGH = 8'h06;
  localparam logic [7:0] OFF_TEMP_LOW = 8'h07;
  localparam logic [7:0] OFF_X_UPPER = 8'h08;
  localparam logic [7:0] OFF_X_MIDDLE = 8'h09;
  localparam logic [7:0] OFF_X_LOWER = 8'h0A;
  localparam logic [7:0] OFF_Y_UPPER = 8'h0B;
  localparam logic [7:0] OFF_Y_MIDDLE = 8'h0C;
  localparam logic [7:0] OFF_Y_LOWER = 8'h0D;
  // condition flag bit positions
  localparam int BIT_SAMPLE_READY = 0;
  localparam int BIT_WATERMARK = 1;
  localparam int BIT_OVERRUN = 2;
  localparam int BIT_MOTION = 3;
  localparam int BIT_NV_BUSY = 4;
  // values after reset
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [6:0] RST_FILL = 7'h00;
  localparam logic [11:0] RST_TEMP = 12'h000;
  localparam logic [19:0] RST_SAMPLE = 20'h00000;
  localparam logic [7:0] RST_RDATA = 8'h00;
  // queue depth limit in samples
  localparam logic [6:0] QUEUE_MAX = 7'h60;
  // nominal temperature transfer: code at 25 C, slope in hundredths of a count per C
  localparam int TEMP_CODE_AT_25C = 1885;
  localparam int TEMP_SLOPE_CENTI = -905;
  // sample field widths
  localparam int SAMPLE_W = 20;
  localparam int TEMP_W = 12;
endpackage

// [src/asr_status_readout.sv]
`timescale 1ns/1ns
module asr_status_readout #(
  parameter logic [7:0] MAKER_CODE = 8'h5A,  // arbitrary value
  parameter logic [7:0] DEVICE_CODE = 8'h3C, // arbitrary value
  parameter logic [7:0] MASK_REVISION = 8'h00 // first revision
) (
  input wire logic clock,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd_en,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  // core events and values, same clock
  input wire logic nonvolatile_busy_in,
  input wire logic motion_detect_in,
  input wire logic queue_overrun_in,
  input wire logic [6:0] queue_fill_in,
  input wire logic [6:0] watermark_level,
  input wire logic sample_valid_in,
  input wire logic [19:0] x_accel_sample_in,
  input wire logic [19:0] y_accel_sample_in,
  input wire logic temp_valid_in,
  input wire logic [11:0] temp_code_in
);

  // sticky flags and live busy bit
  logic nv_busy_reg, nv_busy_next;
  logic motion_reg, motion_next;
  logic overrun_reg, overrun_next;
  logic watermark_reg, watermark_next;
  logic ready_reg, ready_next;
  // held values
  logic [6:0] fill_reg, fill_next;
  logic [11:0] temp_reg, temp_next;
  logic [19:0] x_accel_sample_reg, x_accel_sample_next;
  logic [19:0] y_accel_sample_reg, y_accel_sample_next;
  // read answer
  logic [7:0] rdata_reg, rdata_next;
  logic rd_valid_reg, rd_valid_next;
  // decoded helpers
  logic flags_read;
  logic [7:0] flags_view;
  logic watermark_hit;

  // read-back byte for a given offset, reserved bits zero
  function automatic logic [7:0] read_mux(input logic [7:0] addr, input logic [7:0] flags,
                                          input logic [6:0] fill, input logic [11:0] temp,
                                          input logic [19:0] xs, input logic [19:0] ys);
    logic [7:0] v;
    v = 8'h00;
    unique case (addr)
      asr_pkg::OFF_MAKER_CODE: v = MAKER_CODE;
      asr_pkg::OFF_DEVICE_CODE: v = DEVICE_CODE;
      asr_pkg::OFF_MASK_REVISION: v = MASK_REVISION;
      asr_pkg::OFF_CONDITION_FLAGS: v = flags;
      asr_pkg::OFF_QUEUE_FILL: v = {1'b0, fill};
      asr_pkg::OFF_TEMP_HIGH: v = {4'h0, temp[11:8]};
      asr_pkg::OFF_TEMP_LOW: v = temp[7:0];
      asr_pkg::OFF_X_UPPER: v = xs[19:12];
      asr_pkg::OFF_X_MIDDLE: v = xs[11:4];
      asr_pkg::OFF_X_LOWER: v = {xs[3:0], 4'h0};
      asr_pkg::OFF_Y_UPPER: v = ys[19:12];
      asr_pkg::OFF_Y_MIDDLE: v = ys[11:4];
      asr_pkg::OFF_Y_LOWER: v = {ys[3:0], 4'h0};
      default: v = 8'h00; // unmapped offsets read zero
    endcase
    return v;
  endfunction

  // status byte as software sees it, upper three bits reserved zero
  always_comb begin
    flags_view = 8'h00;
    flags_view[asr_pkg::BIT_NV_BUSY] = nv_busy_reg;
    flags_view[asr_pkg::BIT_MOTION] = motion_reg;
    flags_view[asr_pkg::BIT_OVERRUN] = overrun_reg;
    flags_view[asr_pkg::BIT_WATERMARK] = watermark_reg;
    flags_view[asr_pkg::BIT_SAMPLE_READY] = ready_reg;
  end

  // a status read clears the sticky flags after returning them
  assign flags_read = reg_rd_en && (reg_addr == asr_pkg::OFF_CONDITION_FLAGS);
  assign watermark_hit = (watermark_level != 7'h00) && (fill_next >= watermark_level);

  // next values of flags and held data
  always_comb begin
    // busy follows the controller, it is not sticky
    nv_busy_next = nonvolatile_busy_in;
    // sticky flags: an event in the clearing cycle wins over the clear
    motion_next = motion_detect_in || (motion_reg && !flags_read);
    overrun_next = queue_overrun_in || (overrun_reg && !flags_read);
    ready_next = sample_valid_in || (ready_reg && !flags_read);
    // fill count clamped to the queue depth
    if (queue_fill_in > asr_pkg::QUEUE_MAX) begin
      fill_next = asr_pkg::QUEUE_MAX;
    end else begin
      fill_next = queue_fill_in;
    end
    watermark_next = watermark_hit || (watermark_reg && !flags_read);
    // temperature updates straight away, so a split read may tear
    if (temp_valid_in) begin
      temp_next = temp_code_in;
    end else begin
      temp_next = temp_reg;
    end
    // axis samples captured together on a complete set
    if (sample_valid_in) begin
      x_accel_sample_next = x_accel_sample_in;
      y_accel_sample_next = y_accel_sample_in;
    end else begin
      x_accel_sample_next = x_accel_sample_reg;
      y_accel_sample_next = y_accel_sample_reg;
    end
  end

  // next values of the read answer; writes are never looked at
  always_comb begin
    rd_valid_next = reg_rd_en;
    if (reg_rd_en) begin
      rdata_next = read_mux(reg_addr, flags_view, fill_reg, temp_reg,
                            x_accel_sample_reg, y_accel_sample_reg);
    end else begin
      rdata_next = rdata_reg;
    end
  end

  // register all state
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      nv_busy_reg <= 1'b0;
      motion_reg <= 1'b0;
      overrun_reg <= 1'b0;
      watermark_reg <= 1'b0;
      ready_reg <= 1'b0;
      fill_reg <= asr_pkg::RST_FILL;
      temp_reg <= asr_pkg::RST_TEMP;
      x_accel_sample_reg <= asr_pkg::RST_SAMPLE;
      y_accel_sample_reg <= asr_pkg::RST_SAMPLE;
      rdata_reg <= asr_pkg::RST_RDATA;
      rd_valid_reg <= 1'b0;
    end else begin
      nv_busy_reg <= nv_busy_next;
      motion_reg <= motion_next;
      overrun_reg <= overrun_next;
      watermark_reg <= watermark_next;
      ready_reg <= ready_next;
      fill_reg <= fill_next;
      temp_reg <= temp_next;
      x_accel_sample_reg <= x_accel_sample_next;
      y_accel_sample_reg <= y_accel_sample_next;
      rdata_reg <= rdata_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  // outputs come straight from flip-flops
  assign reg_rdata = rdata_reg;
  assign reg_rd_valid = rd_valid_reg;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // a status read with no new events
  sequence status_read_quiet;
    flags_read && !motion_detect_in && !queue_overrun_in && !sample_valid_in;
  endsequence

  // a read request at a given offset
  sequence read_at(logic [7:0] off);
    reg_rd_en && (reg_addr == off);
  endsequence

  // a complete sample set arriving from the core
  sequence sample_set_in;
    sample_valid_in;
  endsequence

  // any read request, whatever the offset
  sequence any_read;
    reg_rd_en;
  endsequence

  // a quiet status read while the queue is below its watermark
  sequence status_read_calm;
    status_read_quiet ##0 !watermark_hit;
  endsequence

  // busy bit mirrors the controller one cycle late
  chk_busy_follows: assert property (nonvolatile_busy_in |=> flags_view[asr_pkg::BIT_NV_BUSY])
    else $error("busy flag did not follow controller");

  // busy bit drops one cycle after the controller goes idle
  chk_busy_drops: assert property (!nonvolatile_busy_in |=> !flags_view[asr_pkg::BIT_NV_BUSY])
    else $error("busy flag stayed high");

  // an activity event always lands in the flag
  chk_motion_sticky: assert property (motion_detect_in |=> motion_reg)
    else $error("motion flag not set");

  // a status read with no new activity clears the motion flag
  chk_motion_cleared: assert property (flags_read && !motion_detect_in |=> !motion_reg)
    else $error("motion flag not cleared by read");

  // an overrun is kept until software has read it
  chk_overrun_sticky: assert property (queue_overrun_in ##1 !flags_read |=> overrun_reg)
    else $error("overrun flag lost before a read");

  // a status read with no new overrun clears the overrun flag
  chk_overrun_cleared: assert property (flags_read && !queue_overrun_in |=> !overrun_reg)
    else $error("overrun flag not cleared by read");

  // reaching the watermark raises the flag
  chk_watermark_level: assert property (watermark_hit |=> flags_view[asr_pkg::BIT_WATERMARK])
    else $error("watermark flag not set at level");

  // a zero watermark level never raises the flag after a read
  chk_watermark_off: assert property (watermark_level == 7'h00 && flags_read |=> !watermark_reg)
    else $error("watermark flag set while disabled");

  // below the watermark a status read clears the flag
  chk_watermark_cleared: assert property (status_read_calm |=> !watermark_reg)
    else $error("watermark flag not cleared by read");

  // a quiet status read clears the ready, motion and overrun flags
  chk_ready_cleared: assert property (status_read_quiet |=> !ready_reg && !motion_reg && !overrun_reg)
    else $error("sticky flags not cleared by status read");

  // a complete sample set raises the ready flag
  chk_ready_sets: assert property (sample_set_in |=> ready_reg)
    else $error("ready flag not set");

  // status answer arrives with its upper bits zero
  chk_status_reserved: assert property (read_at(asr_pkg::OFF_CONDITION_FLAGS) |=>
                                        reg_rd_valid && reg_rdata[7:5] == 3'h0)
    else $error("status reserved bits not zero");

  // status answer is the flag image of the taking cycle
  chk_status_image: assert property (read_at(asr_pkg::OFF_CONDITION_FLAGS) |=>
                                     reg_rdata == $past(flags_view))
    else $error("status answer wrong");

  // fill count never passes the queue depth
  chk_fill_bound: assert property (fill_reg <= asr_pkg::QUEUE_MAX)
    else $error("fill count above queue depth");

  // an out-of-range count from the core is clamped
  chk_fill_clamp: assert property (queue_fill_in > asr_pkg::QUEUE_MAX |=>
                                   fill_reg == asr_pkg::QUEUE_MAX)
    else $error("fill count not clamped");

  // fill count reads back with its top bit zero
  chk_fill_readback: assert property (read_at(asr_pkg::OFF_QUEUE_FILL) |=>
                                      reg_rdata == {1'b0, $past(fill_reg)})
    else $error("fill count register wrong");

  // temperature high register holds the top nibble only
  chk_temp_split: assert property (read_at(asr_pkg::OFF_TEMP_HIGH) |=>
                                   reg_rdata == {4'h0, $past(temp_reg[11:8])})
    else $error("temperature high register wrong");

  // temperature low register holds the low byte
  chk_temp_low: assert property (read_at(asr_pkg::OFF_TEMP_LOW) |=>
                                 reg_rdata == $past(temp_reg[7:0]))
    else $error("temperature low register wrong");

  // a new code replaces the held one at once
  chk_temp_unbuffered: assert property (temp_valid_in |=> temp_reg == $past(temp_code_in))
    else $error("temperature did not update at once");

  // the raw code is held unchanged between updates
  chk_temp_hold: assert property (!temp_valid_in |=> $stable(temp_reg))
    else $error("temperature changed without update");

  // x lower register carries the low nibble left justified
  chk_x_lower_nibble: assert property (sample_valid_in ##1 read_at(asr_pkg::OFF_X_LOWER) |=>
                                       reg_rdata == {$past(x_accel_sample_in[3:0], 2), 4'h0})
    else $error("x lower register wrong");

  // x upper register carries the top byte
  chk_x_upper_byte: assert property (read_at(asr_pkg::OFF_X_UPPER) |=>
                                     reg_rdata == $past(x_accel_sample_reg[19:12]))
    else $error("x upper register wrong");

  // x middle register carries the middle byte
  chk_x_middle_byte: assert property (read_at(asr_pkg::OFF_X_MIDDLE) |=>
                                      reg_rdata == $past(x_accel_sample_reg[11:4]))
    else $error("x middle register wrong");

  // y upper byte captured with the set
  chk_y_upper_byte: assert property (sample_valid_in |=>
                                     y_accel_sample_reg[19:12] == $past(y_accel_sample_in[19:12]))
    else $error("y upper byte wrong");

  // y middle register carries the middle byte
  chk_y_middle_byte: assert property (read_at(asr_pkg::OFF_Y_MIDDLE) |=>
                                      reg_rdata == $past(y_accel_sample_reg[11:4]))
    else $error("y middle register wrong");

  // y lower register carries the low nibble left justified
  chk_y_lower_nibble: assert property (read_at(asr_pkg::OFF_Y_LOWER) |=>
                                       reg_rdata == {$past(y_accel_sample_reg[3:0]), 4'h0})
    else $error("y lower register wrong");

  // y sample held between sets
  chk_y_held: assert property (!sample_valid_in |=> $stable(y_accel_sample_reg))
    else $error("y sample changed without a set");

  // mask revision reads its fixed code
  chk_revision_fixed: assert property (read_at(asr_pkg::OFF_MASK_REVISION) |=> reg_rdata == MASK_REVISION)
    else $error("mask revision changed");

  // device code reads its fixed value
  chk_device_code: assert property (read_at(asr_pkg::OFF_DEVICE_CODE) |=> reg_rdata == DEVICE_CODE)
    else $error("device code wrong");

  // maker code reads its fixed value
  chk_maker_code: assert property (read_at(asr_pkg::OFF_MAKER_CODE) |=> reg_rdata == MAKER_CODE)
    else $error("maker code wrong");

  // a write never reaches the held sample
  chk_write_ignored: assert property (reg_wr_en && !sample_valid_in |=> $stable(x_accel_sample_reg))
    else $error("write changed a read-only register");

  // a write alone gets no answer
  chk_write_no_answer: assert property (reg_wr_en && !reg_rd_en |=> !reg_rd_valid)
    else $error("write produced an answer");

  // every read is answered one cycle later
  chk_read_answer: assert property (any_read |=> reg_rd_valid)
    else $error("read not answered");

  // read data holds between answers
  chk_rdata_hold: assert property (!reg_rd_en |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  // unmapped offsets read zero
  chk_unmapped_zero: assert property (reg_rd_en && (reg_addr == 8'h00 || reg_addr > asr_pkg::OFF_Y_LOWER) |=>
                                      reg_rdata == 8'h00)
    else $error("unmapped offset not zero");

endmodule

// [tb/asr_host_model.sv]
`timescale 1ns/1ns
// host on the register port: one-cycle strobes, answer picked up in the following cycle
module asr_host_model (
  input wire logic clock,
  output logic [7:0] reg_addr,
  output logic reg_rd_en,
  output logic reg_wr_en,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_valid
);
  // idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_rd_en = 1'b0;
    reg_wr_en = 1'b0;
    reg_wdata = 8'h00;
  end
  // one read: request held up to the taking edge, answer sampled in the next cycle
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge clock);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd_en <= 1'b0;
    reg_addr <= ~a; // stale address must not matter
    #1;
    ok = reg_rd_valid;
    d = reg_rdata;
  endtask
  // one write strobe, which the block must ignore
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr_en <= 1'b0;
    reg_wdata <= ~d;
  endtask
endmodule

// [tb/tb_asr_status_readout.sv]
`timescale 1ns/1ns
module tb_asr_status_readout;
  typedef struct {logic [7:0] a; logic [7:0] e;} asr_row_t;
  logic clock = 1'b0; // 100 MHz
  logic sys_rst = 1'b1; // synchronous, active high
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
  logic reg_rd_en, reg_wr_en, reg_rd_valid, ok;
  logic busy = 1'b0, motion = 1'b0, ovr = 1'b0, sv = 1'b0, tv = 1'b0;
  logic [6:0] fill = 7'h00, wm = 7'h10;
  logic [19:0] xs = 20'h00000, ys = 20'h00000;
  logic [11:0] tc = 12'h000;
  int err_total = 0, n_checks = 0;
  // offset beside the byte it should read once all core values are loaded
  asr_row_t rows [13] = '{'{8'h04, 8'h1F}, '{8'h01, 8'h5A}, '{8'h02, 8'h3C}, '{8'h03, 8'h00},
    '{8'h05, 8'h60}, '{8'h06, 8'h07}, '{8'h07, 8'h5D}, '{8'h08, 8'hA5}, '{8'h09, 8'hC3},
    '{8'h0A, 8'hE0}, '{8'h0B, 8'h1F}, '{8'h0C, 8'h0E}, '{8'h0D, 8'h70}};
  always #5 clock = ~clock;
  asr_host_model u_host (.clock(clock), .reg_addr(reg_addr), .reg_rd_en(reg_rd_en), .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid));
  asr_status_readout u_dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_rd_en(reg_rd_en),
    .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .nonvolatile_busy_in(busy), .motion_detect_in(motion), .queue_overrun_in(ovr), .queue_fill_in(fill),
    .watermark_level(wm), .sample_valid_in(sv), .x_accel_sample_in(xs), .y_accel_sample_in(ys),
    .temp_valid_in(tv), .temp_code_in(tc));
  // compare one value and count it
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // read through the host and check valid strobe and data
  task rd_chk(input logic [7:0] a, input logic [7:0] e);
    u_host.read_reg(a, rd, ok);
    chk("read valid", 8'h01, {7'h00, ok});
    chk($sformatf("offset %h", a), e, rd);
  endtask
  // counts, verdict and end of run
  task wrap_up;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    #100000;
    err_total++;
    wrap_up;
  end
  initial begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    rd_chk(8'h04, 8'h00);
    rd_chk(8'h08, 8'h00);
    // every event at once, full queue, sample and temperature loaded
    @(posedge clock);
    {busy, motion, ovr, sv, tv} <= 5'h1F;
    fill <= 7'h60;
    xs <= 20'hA5C3E;
    ys <= 20'h1F0E7;
    tc <= 12'h75D;
    @(posedge clock);
    {motion, ovr, sv, tv} <= 4'h0;
    foreach (rows[i]) rd_chk(rows[i].a, rows[i].e);
    rd_chk(8'h0E, 8'h00);
    u_host.write_reg(8'h08, 8'hFF);
    rd_chk(8'h08, 8'hA5);
    // busy drops and queue empties: watermark stays until read, then clears
    @(posedge clock);
    busy <= 1'b0;
    fill <= 7'h00;
    @(posedge clock);
    rd_chk(8'h04, 8'h02);
    rd_chk(8'h04, 8'h00);
    // temperature changes between the two half reads
    rd_chk(8'h06, 8'h07);
    @(posedge clock);
    tv <= 1'b1;
    tc <= 12'h8A1;
    @(posedge clock);
    tv <= 1'b0;
    rd_chk(8'h07, 8'hA1);
    // watermark disabled and an out-of-range fill count from the core
    @(posedge clock);
    wm <= 7'h00;
    fill <= 7'h7F;
    rd_chk(8'h05, 8'h60);
    rd_chk(8'h04, 8'h00);
    // reset in mid-run clears captured values
    @(posedge clock);
    sys_rst <= 1'b1;
    @(posedge clock);
    sys_rst <= 1'b0;
    rd_chk(8'h07, 8'h00);
    wrap_up;
  end
endmodule
